/* hw/uart_fsc_pkg.sv */
// Constants, register map and types of the UART frame, status and control block
// Summary of operation
// R1 - High-speed select gives 4 baud ticks per bit, otherwise 16.
// R2 - Format field: 11 nine bits, 10 odd, 01 even, 00 eight no parity.
// R3 - Stop select set sends two stop bits, clear sends one.
// R4 - Tx mode 10 interrupts when a load into the shifter empties the buffer.
// R5 - Tx mode 01 interrupts when the last character is fully shifted out.
// R6 - Tx mode 00 interrupts on every load; software never uses mode 11.
// R7 - With infrared on, polarity bit sets the transmit idle level.
// R8 - Send-break sends start, twelve zeros, stop, then clears itself.
// R9 - Clearing transmit enable aborts, flushes buffer, releases the pin.
// R10 - Transmit-full reads 1 while no further character can be written.
// R11 - Shift-empty reads 1 only when shifter and buffer are empty; resets 1.
// R12 - Rx mode 11 interrupts when a transfer fills the four-entry buffer.
// R13 - Rx mode 10 interrupts when a transfer leaves three characters.
// R14 - Rx modes 0x interrupt on every transfer into the buffer.
// R15 - Address detect in nine-bit format keeps only ninth-bit-set characters.
// R16 - Receiver-idle reads 1 when no character is being received; resets 1.
// R17 - Parity and framing flags describe only the head character.
// R18 - Overflow sets overrun; clearing it empties buffer and shift register.
// R19 - Data-available reads 1 while the receive buffer holds a character.
// R20 - Reading the holding word brings the next character to the head.
// R21 - Writing the divisor clears the baud timer at once.
// R22 - Infrared enable routes the pins through the infrared codec; the code routes only the transmit pin, the receive pin bypasses it.
// R23 - Low first stop bit flags framing error; parity mismatch flags parity.
package uart_fsc_pkg;
    // Register word offsets (byte address = 4 * index)
    localparam logic [2:0]  OFS_MODE  = 3'h0;
    localparam logic [2:0]  OFS_STA   = 3'h1;
    localparam logic [2:0]  OFS_TXREG = 3'h2;
    localparam logic [2:0]  OFS_RXREG = 3'h3;
    localparam logic [2:0]  OFS_BRG   = 3'h4;
    // Mode register fields
    localparam int          M_IR_ON   = 12;
    localparam int          M_HISPEED = 3;
    localparam int          M_FORMAT  = 1;
    localparam int          M_STOP2   = 0;
    // Status register fields
    localparam int          S_TXIS1   = 15;
    localparam int          S_TXINV   = 14;
    localparam int          S_TXIS0   = 13;
    localparam int          S_BRK     = 11;
    localparam int          S_TXEN    = 10;
    localparam int          S_RXIS    = 6;
    localparam int          S_ADDRDET = 5;
    localparam int          S_OVRN    = 1;
    // Reset values
    localparam logic [15:0] MODE_RST  = 16'h0000;
    localparam logic [15:0] BRG_RST   = 16'h0000;
    // Ticks per bit less one, break frame length in bits, receive buffer depth
    localparam logic [3:0]  TICKS_HI  = 4'h3;
    localparam logic [3:0]  TICKS_STD = 4'hF;
    localparam logic [3:0]  BREAK_LEN = 4'hE;
    localparam int          RX_DEPTH  = 4;

    typedef struct packed {
        logic       par_err;
        logic       frm_err;
        logic [8:0] data;
    } rx_char_t;

    typedef enum logic [1:0] {FMT_8N, FMT_8E, FMT_8O, FMT_9N} fmt_t;
endpackage

/* hw/uart_fsc.sv */
// UART frame format, transmit/receive control and status with Avalon-MM slave
`timescale 1ns/100ps
module uart_fsc
    import uart_fsc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Avalon-MM slave
    input  wire logic [2:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [3:0]  byteenable_i,
    input  wire logic [31:0] writedata_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // Serial pins
    input  wire logic        rx_pin_i,
    output logic             serial_out_pin_o,
    output logic             serial_out_oe_o,
    // Interrupt requests
    output logic             tx_irq_o,
    output logic             rx_irq_o
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [15:0] mode_r;
    logic [15:0] baud_divisor_r;
    logic [1:0]  tx_irq_mode_r;
    logic        infrared_tx_polarity_r;
    logic        send_break_r;
    logic        tx_enable_r;
    logic [1:0]  rx_irq_mode_r;
    logic        address_detect_enable_r;
    logic        overrun_error_flag_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    logic        acc_w;
    logic        acc_r;
    fmt_t        fmt;
    logic        infrared_codec_enable;
    logic [3:0]  bit_last;

    assign fmt                   = fmt_t'(mode_r[M_FORMAT+:2]);
    assign infrared_codec_enable = mode_r[M_IR_ON];
    // R1 ticks per bit
    assign bit_last = mode_r[M_HISPEED] ? TICKS_HI : TICKS_STD;
    assign acc_w    = write_i && !wait_r;
    assign acc_r    = read_i && !wait_r;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Baud generator
    logic [15:0] brg_cnt_r;
    logic        tick;
    assign tick = (brg_cnt_r == baud_divisor_r);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            brg_cnt_r <= 16'h0000;
        // R21 divisor write restarts
        end else if (acc_w && address_i == OFS_BRG) begin
            brg_cnt_r <= 16'h0000;
        end else if (tick) begin
            brg_cnt_r <= 16'h0000;
        end else begin
            brg_cnt_r <= brg_cnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchroniser: change taken when stages two and three agree
    logic [2:0] rx_sync_r;
    logic       rx_lvl_r;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_sync_r <= 3'h7;
            rx_lvl_r  <= 1'b1;
        end else begin
            rx_sync_r <= {rx_sync_r[1:0], rx_pin_i};
            if (rx_sync_r[1] == rx_sync_r[2]) begin
                rx_lvl_r <= rx_sync_r[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmitter: one holding word plus shifter
    logic [8:0]  tx_buf_r;
    logic        tx_buf_v_r;
    logic        tx_busy_r;
    logic        tx_brk_r;
    logic [13:0] tx_sh_r;
    logic [3:0]  tx_bits_r;
    logic [3:0]  tx_sub_r;
    logic        tx_load;
    logic        tx_done;
    logic        tx_wr;
    logic [13:0] tx_frame;
    logic [3:0]  tx_len;

    assign tx_wr   = acc_w && address_i == OFS_TXREG && byteenable_i[0];
    assign tx_load = tx_enable_r && tx_buf_v_r && !tx_busy_r;
    assign tx_done = tx_busy_r && tick && tx_sub_r == bit_last && tx_bits_r == 4'h0;

    always_comb begin
        // R2 frame layout, R3 stop bits, R8 break frame
        tx_frame = 14'h3FFF;
        tx_len   = 4'h9 + {3'h0, fmt != FMT_8N} + {3'h0, mode_r[M_STOP2]};
        case (fmt)
            FMT_9N:  tx_frame[9:0] = {tx_buf_r, 1'b0};
            FMT_8E:  tx_frame[10:0] = {1'b1, ^tx_buf_r[7:0], tx_buf_r[7:0], 1'b0};
            FMT_8O:  tx_frame[10:0] = {1'b1, ~^tx_buf_r[7:0], tx_buf_r[7:0], 1'b0};
            default: tx_frame[8:0] = {tx_buf_r[7:0], 1'b0};
        endcase
        if (send_break_r) begin
            tx_frame = 14'h2000;
            tx_len   = BREAK_LEN - 4'h1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_buf_r   <= 9'h000;
            tx_buf_v_r <= 1'b0;
        // R9 abort flushes the buffer
        end else if (acc_w && address_i == OFS_STA && byteenable_i[1] && !writedata_i[S_TXEN]) begin
            tx_buf_v_r <= 1'b0;
        end else if (tx_wr && (!tx_buf_v_r || tx_load)) begin
            tx_buf_r   <= writedata_i[8:0];
            tx_buf_v_r <= 1'b1;
        end else if (tx_load) begin
            tx_buf_v_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_busy_r <= 1'b0;
            tx_brk_r  <= 1'b0;
            tx_sh_r   <= 14'h3FFF;
            tx_bits_r <= 4'h0;
            tx_sub_r  <= 4'h0;
        // R9 abort stops the shifter
        end else if (!tx_enable_r) begin
            tx_busy_r <= 1'b0;
            tx_sh_r   <= 14'h3FFF;
        end else if (tx_load) begin
            tx_busy_r <= 1'b1;
            tx_brk_r  <= send_break_r;
            tx_sh_r   <= tx_frame;
            tx_bits_r <= tx_len;
            tx_sub_r  <= 4'h0;
        end else if (tx_busy_r && tick) begin
            tx_sub_r <= (tx_sub_r == bit_last) ? 4'h0 : tx_sub_r + 4'h1;
            if (tx_sub_r == bit_last) begin
                tx_sh_r   <= {1'b1, tx_sh_r[13:1]};
                tx_bits_r <= tx_bits_r - 4'h1;
                tx_busy_r <= (tx_bits_r != 4'h0);
            end
        end
    end

    // R7 idle level, R22 infrared path, R9 pin ownership
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_out_pin_o <= 1'b1;
            serial_out_oe_o  <= 1'b0;
        end else begin
            serial_out_oe_o <= tx_enable_r;
            if (infrared_codec_enable) begin
                serial_out_pin_o <= (tx_busy_r ? tx_sh_r[0] : 1'b1) ~^ infrared_tx_polarity_r;
            end else begin
                serial_out_pin_o <= tx_busy_r ? tx_sh_r[0] : 1'b1;
            end
        end
    end

    // R4 R5 R6 transmit interrupt selection
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_irq_o <= 1'b0;
        end else begin
            case (tx_irq_mode_r)
                2'b10:   tx_irq_o <= tx_load && !tx_wr;
                2'b01:   tx_irq_o <= tx_done && !tx_buf_v_r;
                2'b00:   tx_irq_o <= tx_load;
                default: tx_irq_o <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receiver
    typedef enum logic {RX_IDLE, RX_BITS} rx_state_t;
    rx_state_t   rx_state_r;
    logic [11:0] rx_shift_register_r;
    logic [3:0]  rx_idx_r;
    logic [3:0]  rx_sub_r;
    logic [3:0]  rx_len;
    logic        rx_sample;
    logic        rx_end;
    logic        rx_keep;
    logic        rx_push;
    logic        rx_pop;
    logic        ovr_clr;
    logic        ovf;
    rx_char_t    rx_new;
    rx_char_t    rx_fifo_r [RX_DEPTH];
    logic [1:0]  rx_wp_r;
    logic [1:0]  rx_rp_r;
    logic [2:0]  rx_count_r;

    assign rx_len    = 4'h9 + {3'h0, fmt != FMT_8N};
    assign rx_sample = rx_state_r == RX_BITS && tick && rx_sub_r == {1'b0, bit_last[3:1]};
    assign rx_end    = rx_sample && rx_idx_r == rx_len;
    assign ovr_clr   = acc_w && address_i == OFS_STA && byteenable_i[0]
                       && overrun_error_flag_r && !writedata_i[S_OVRN];

    always_comb begin
        rx_new.data = (fmt == FMT_9N) ? rx_shift_register_r[9:1]
                                      : {1'b0, rx_shift_register_r[8:1]};
        // R23 error detection
        rx_new.frm_err = !rx_lvl_r;
        case (fmt)
            FMT_8E:  rx_new.par_err = ^rx_shift_register_r[9:1];
            FMT_8O:  rx_new.par_err = ~^rx_shift_register_r[9:1];
            default: rx_new.par_err = 1'b0;
        endcase
    end

    // R15 address filter only in nine-bit format
    assign rx_keep = !(address_detect_enable_r && fmt == FMT_9N && !rx_shift_register_r[9]);
    assign rx_push = rx_end && rx_keep && !ovr_clr && rx_count_r != 3'h4;
    assign ovf     = rx_end && rx_keep && rx_count_r == 3'h4;
    assign rx_pop  = acc_r && address_i == OFS_RXREG && rx_count_r != 3'h0;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_state_r          <= RX_IDLE;
            rx_shift_register_r <= 12'h000;
            rx_idx_r            <= 4'h0;
            rx_sub_r            <= 4'h0;
        end else begin
            case (rx_state_r)
                RX_IDLE: begin
                    rx_idx_r <= 4'h0;
                    rx_sub_r <= 4'h0;
                    if (!rx_lvl_r && !ovr_clr) begin
                        rx_state_r <= RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (tick) begin
                        rx_sub_r <= (rx_sub_r == bit_last) ? 4'h0 : rx_sub_r + 4'h1;
                        if (rx_sub_r == bit_last) begin
                            rx_idx_r <= rx_idx_r + 4'h1;
                        end
                    end
                    if (rx_sample) begin
                        rx_shift_register_r[rx_idx_r] <= rx_lvl_r;
                    end
                    // R18 overrun clear empties the shift register
                    if (ovr_clr || rx_end || (rx_sample && rx_idx_r == 4'h0 && rx_lvl_r)) begin
                        rx_state_r <= RX_IDLE;
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // R20 read advances head, R18 clear flushes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_wp_r    <= 2'h0;
            rx_rp_r    <= 2'h0;
            rx_count_r <= 3'h0;
        end else if (ovr_clr && !ovf) begin
            rx_wp_r    <= 2'h0;
            rx_rp_r    <= 2'h0;
            rx_count_r <= 3'h0;
        end else begin
            if (rx_push) begin
                rx_wp_r <= rx_wp_r + 2'h1;
            end
            if (rx_pop) begin
                rx_rp_r <= rx_rp_r + 2'h1;
            end
            rx_count_r <= rx_count_r + {2'h0, rx_push} - {2'h0, rx_pop};
        end
    end

    // Character storage needs no reset: data and flags are masked while empty
    always_ff @(posedge clk_i) begin
        if (rx_push) begin
            rx_fifo_r[rx_wp_r] <= rx_new;
        end
    end

    // R12 R13 R14 receive interrupt selection
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_irq_o <= 1'b0;
        end else begin
            case (rx_irq_mode_r)
                2'b11:   rx_irq_o <= rx_push && rx_count_r == 3'h3 && !rx_pop;
                2'b10:   rx_irq_o <= rx_push && rx_count_r == 3'h2 + {2'h0, rx_pop};
                default: rx_irq_o <= rx_push;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_r                  <= MODE_RST;
            baud_divisor_r          <= BRG_RST;
            tx_irq_mode_r           <= 2'b00;
            infrared_tx_polarity_r  <= 1'b0;
            tx_enable_r             <= 1'b0;
            rx_irq_mode_r           <= 2'b00;
            address_detect_enable_r <= 1'b0;
        end else if (acc_w) begin
            if (address_i == OFS_MODE) begin
                mode_r <= merge16(mode_r, writedata_i, byteenable_i) & 16'h100F;
            end
            if (address_i == OFS_BRG) begin
                baud_divisor_r <= merge16(baud_divisor_r, writedata_i, byteenable_i);
            end
            if (address_i == OFS_STA && byteenable_i[1]) begin
                tx_irq_mode_r          <= {writedata_i[S_TXIS1], writedata_i[S_TXIS0]};
                infrared_tx_polarity_r <= writedata_i[S_TXINV];
                tx_enable_r            <= writedata_i[S_TXEN];
            end
            if (address_i == OFS_STA && byteenable_i[0]) begin
                rx_irq_mode_r           <= writedata_i[S_RXIS+:2];
                address_detect_enable_r <= writedata_i[S_ADDRDET];
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            send_break_r <= 1'b0;
        // R8 hardware clears the break when it completes
        end else if (tx_done && tx_brk_r) begin
            send_break_r <= 1'b0;
        end else if (acc_w && address_i == OFS_STA && byteenable_i[1]) begin
            send_break_r <= writedata_i[S_BRK];
        end
    end

    // R18 overflow sets, software can only clear; set wins
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            overrun_error_flag_r <= 1'b0;
        end else if (ovf) begin
            overrun_error_flag_r <= 1'b1;
        end else if (ovr_clr) begin
            overrun_error_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait cycle, read data sampled at the edge that ends the wait cycle
    logic [15:0] sta_word;
    rx_char_t    rx_head;
    assign rx_head = rx_fifo_r[rx_rp_r];
    always_comb begin
        sta_word = {tx_irq_mode_r[1], infrared_tx_polarity_r, tx_irq_mode_r[0], 1'b0,
                    send_break_r, tx_enable_r,
                    tx_buf_v_r,                                  // R10 full flag
                    !tx_busy_r && !tx_buf_v_r,                   // R11 shift empty
                    rx_irq_mode_r, address_detect_enable_r,
                    rx_state_r == RX_IDLE,                       // R16 idle flag
                    rx_count_r != 3'h0 && rx_head.par_err,       // R17 head flags
                    rx_count_r != 3'h0 && rx_head.frm_err,
                    overrun_error_flag_r,
                    rx_count_r != 3'h0};                         // R19 data available
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= !(read_i || write_i) || !wait_r;
            if (read_i && wait_r) begin
                case (address_i)
                    OFS_MODE:  rdata_r <= {16'h0000, mode_r};
                    OFS_STA:   rdata_r <= {16'h0000, sta_word};
                    OFS_RXREG: rdata_r <= {23'h000000, rx_count_r != 3'h0 ? rx_head.data : 9'h000};
                    OFS_BRG:   rdata_r <= {16'h0000, baud_divisor_r};
                    default:   rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign readdata_o    = rdata_r;
    assign waitrequest_o = wait_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    chk_baud_restart: assert property (acc_w && address_i == OFS_BRG |=> brg_cnt_r == 16'h0000) // R21
        else $error("baud timer not cleared by divisor write");
    chk_shift_empty: assert property (!tx_busy_r && !tx_buf_v_r |-> sta_word[8]) // R11
        else $error("shift-empty flag wrong");
    chk_tx_abort: assert property (!tx_enable_r |=> !tx_busy_r && !serial_out_oe_o) // R9
        else $error("transmit not aborted when disabled");
    chk_break_clear: assert property (tx_done && tx_brk_r |=> !send_break_r) // R8
        else $error("break bit not cleared");
    chk_idle_level: assert property (infrared_codec_enable && !tx_busy_r
        |=> serial_out_pin_o == $past(infrared_tx_polarity_r)) // R7
        else $error("infrared idle level wrong");
    chk_rx_full_irq: assert property (rx_irq_mode_r == 2'b11 && rx_push && !rx_pop
        && rx_count_r == 3'h3 |=> rx_irq_o && rx_count_r == 3'h4) // R12
        else $error("full-buffer interrupt missing");
    chk_rx_any_irq: assert property (!rx_irq_mode_r[1] && rx_push |=> rx_irq_o) // R14
        else $error("receive interrupt missing");
    chk_overrun_flush: assert property (ovr_clr && !ovf |=> rx_count_r == 3'h0
        && rx_state_r == RX_IDLE) // R18
        else $error("overrun clear did not flush");
    chk_tx_done_irq: assert property (tx_irq_mode_r == 2'b01 && tx_done && !tx_buf_v_r
        |=> tx_irq_o) // R5
        else $error("transmit-complete interrupt missing");
    chk_bus_answer: assert property ((read_i || write_i) && wait_r |=> !waitrequest_o
        ##1 waitrequest_o)
        else $error("bus answer not one wait cycle");

    cov_break_sent: cover property (tx_done && tx_brk_r);
    cov_overrun: cover property (ovf);
    cov_rx_push: cover property (rx_push && fmt == FMT_9N);
    cov_tx_frame: cover property (tx_done && !tx_brk_r);
endmodule

/* sim/uart_peer.sv */
// Serial peer model: drives the receive line and captures transmitted frames
`timescale 1ns/100ps
module uart_peer #(
    parameter int BIT = 4
) (
    input  wire logic clk_i,
    input  wire logic line_i,
    output logic      line_o
);
    initial line_o = 1'b1;

    // Start bit, n bits LSB first, one stop bit; idle high after
    task automatic send(input logic [9:0] bits, input int n);
        @(posedge clk_i);
        line_o <= 1'b0;
        repeat (BIT) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            line_o <= bits[i];
            repeat (BIT) @(posedge clk_i);
        end
        line_o <= 1'b1;
        repeat (BIT) @(posedge clk_i);
    endtask

    // Samples n bits after the start bit, near each bit centre
    task automatic recv(input int n, output logic [13:0] bits);
        bits = '0;
        @(negedge line_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (BIT) @(posedge clk_i);
            bits[i] = line_i;
        end
    endtask
endmodule

/* sim/tb_uart_fsc.sv */
// Self-checking bench for the UART frame, status and control block
`timescale 1ns/100ps
module tb_uart_fsc;
    import uart_fsc_pkg::*;
    logic        clk_i = 0, nrst_i = 0, read_i = 0, write_i = 0, rx_pin;
    logic [2:0]  address_i = '0;
    logic [31:0] writedata_i = '0, readdata_o, rd;
    logic        waitrequest_o, serial_out_pin_o, serial_out_oe_o, tx_irq_o, rx_irq_o;
    logic [13:0] got;
    logic [7:0]  d;
    logic [15:0] v;
    logic [7:0]  q [5];
    int          bad_count = 0, compares = 0, tx_n = 0, rx_n = 0, n0;

    uart_fsc uart_fsc_i (.clk_i(clk_i), .nrst_i(nrst_i), .address_i(address_i),
        .read_i(read_i), .write_i(write_i), .byteenable_i(4'hF), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .rx_pin_i(rx_pin),
        .serial_out_pin_o(serial_out_pin_o), .serial_out_oe_o(serial_out_oe_o),
        .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
    uart_peer uart_peer_i (.clk_i(clk_i), .line_i(serial_out_pin_o), .line_o(rx_pin));

    initial begin
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        tx_n += int'(tx_irq_o === 1'b1);
        rx_n += int'(rx_irq_o === 1'b1);
    end

    ////////////////////////////////////////////////////////////////
    task automatic bus(input logic wr, input logic [2:0] a, input logic [15:0] v);
        @(posedge clk_i);
        address_i <= a;
        writedata_i <= {16'h0000, v};
        read_i <= !wr;
        write_i <= wr;
        @(posedge clk_i iff waitrequest_o === 1'b0);
        rd = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Data bits then parity bit; bad flips the parity
    function automatic logic [9:0] frm(input logic [7:0] v, input logic odd, input logic bad);
        return {1'b0, ^v ^ odd ^ bad, v};
    endfunction
    task automatic rx_burst(input int n);
        for (int i = 0; i < n; i++) begin
            q[i] = 8'($urandom);
            uart_peer_i.send(frm(q[i], 1'b0, 1'b0), 8);
        end
        repeat (12) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        final_report();
    end

    initial begin
        void'($urandom(51091));
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        bus(0, OFS_STA, 0);
        chk("status reset", 32'h0000_0110, rd);
        bus(0, 3'h5, 0);
        chk("unmapped read", 0, rd);
        v = 16'($urandom);
        bus(1, OFS_BRG, v);
        bus(0, OFS_BRG, 0);
        chk("divisor", {16'h0000, v}, rd);
        bus(1, OFS_BRG, 16'h0000);
        $display("test reset done");
        bus(1, OFS_MODE, 16'h0008);
        bus(1, OFS_STA, 16'h0400);
        repeat (2) @(posedge clk_i);
        chk("pin owned", 1, serial_out_oe_o);
        repeat (3) begin
            d = 8'($urandom);
            n0 = tx_n;
            fork
                uart_peer_i.recv(9, got);
                bus(1, OFS_TXREG, {8'h00, d});
            join
            chk("tx frame", {1'b1, d}, 32'(got[8:0]));
            chk("tx irq", 1, tx_n > n0);
            repeat (8) @(posedge clk_i);
            bus(0, OFS_STA, 0);
            chk("tx idle flags", 2'b01, rd[9:8]);
        end
        bus(1, OFS_MODE, 16'h1008);
        repeat (2) @(posedge clk_i);
        chk("ir idle level", 0, serial_out_pin_o);
        bus(1, OFS_MODE, 16'h0008);
        bus(1, OFS_STA, 16'h2C00);
        n0 = tx_n;
        fork
            uart_peer_i.recv(13, got);
            bus(1, OFS_TXREG, 16'h0000);
        join
        chk("break frame", 32'h0000_1000, 32'(got[12:0]));
        repeat (8) @(posedge clk_i);
        bus(0, OFS_STA, 0);
        chk("break cleared", 2'b01, {rd[11], rd[8]});
        chk("tx done irq", 1, tx_n - n0);
        bus(1, OFS_STA, 16'h0000);
        repeat (2) @(posedge clk_i);
        chk("pin released", 0, serial_out_oe_o);
        $display("test transmit done");
        bus(1, OFS_STA, 16'h00C0);
        n0 = rx_n;
        rx_burst(4);
        chk("rx irq full", 1, rx_n - n0);
        for (int i = 0; i < 4; i++) begin
            bus(0, OFS_RXREG, 0);
            chk("rx data", q[i], rd[7:0]);
        end
        bus(0, OFS_STA, 0);
        chk("rx empty", 0, rd[0]);
        bus(1, OFS_STA, 16'h0080);
        n0 = rx_n;
        rx_burst(5);
        chk("rx irq three", 1, rx_n - n0);
        bus(0, OFS_STA, 0);
        chk("overrun set", 2'b11, rd[1:0]);
        bus(1, OFS_STA, 16'h0000);
        bus(0, OFS_STA, 0);
        chk("overrun cleared", 2'b00, rd[1:0]);
        $display("test receive done");
        bus(1, OFS_MODE, 16'h000A);
        d = 8'($urandom);
        n0 = rx_n;
        uart_peer_i.send(frm(d, 1'b0, 1'b1), 9);
        repeat (12) @(posedge clk_i);
        chk("rx irq any", 1, rx_n - n0);
        bus(0, OFS_STA, 0);
        chk("parity flag", 3'b101, {rd[3:2], rd[0]});
        bus(0, OFS_RXREG, 0);
        chk("parity data", d, rd[7:0]);
        bus(1, OFS_MODE, 16'h000E);
        bus(1, OFS_STA, 16'h0020);
        uart_peer_i.send({2'b00, ~d}, 9);
        uart_peer_i.send({2'b01, d}, 9);
        repeat (12) @(posedge clk_i);
        bus(0, OFS_RXREG, 0);
        chk("address char", {1'b1, d}, rd[8:0]);
        bus(0, OFS_STA, 0);
        chk("address only", 0, rd[0]);
        $display("test parity done");
        final_report();
    end
endmodule
